// [design/remote_transport_control.sv]
// Our own choices: strobed register access and the placing of the registers.
`default_nettype none
module remote_transport_control
	import remote_ctrl_pkg::*;
#(
	parameter int unsigned FRAME_CYCLES = INTERNAL_FRAME_CYCLES,
	parameter int unsigned SHOW_CYCLES  = LOCATE_SHOW_CYCLES,
	parameter int unsigned FLASH_CYCLES = SHUTTLE_FLASH_CYCLES
)(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [31:0] reg_rdata,
	input  wire logic        cmd_valid,
	input  wire logic [1:0]  cmd_source,
	input  wire logic [3:0]  cmd_code,
	input  wire logic        cmd_track_digital,
	input  wire logic [2:0]  cmd_track_index,
	input  wire logic [23:0] cmd_position,
	input  wire logic        local_valid,
	input  wire logic [3:0]  local_code,
	input  wire logic [2:0]  local_track,
	input  wire logic        video_frame_edge,
	input  wire logic        video_sync_valid,
	input  wire logic        chase_active,
	input  wire logic        tc_linked,
	input  wire logic        tc_reference,
	input  wire logic        master_record,
	input  wire logic        locate_reached,
	output logic             record_active,
	output logic             monitor_input,
	output logic             transport_play,
	output logic             transport_pause,
	output logic             transport_wind,
	output logic             wind_reverse,
	output logic             wind_fast,
	output logic             locate_request,
	output logic      [23:0] locate_target,
	output logic             target_display,
	output logic             ffwd_lamp,
	output logic             rew_lamp,
	output logic             shuttle_lamp,
	output logic             tally_stop,
	output logic             tally_still,
	output logic             identity_valid,
	output logic      [15:0] identity_code,
	output logic      [7:0]  track_arm,
	output logic             tc_track_arm
);

	////////////////////////////////////////////////////////////////
	// register file

	logic [7:0] ctrl;
	logic [2:0] emulation;
	logic [3:0] record_start_delay;
	logic [2:0] map_preset;

	wire       wr_control  = reg_write && reg_addr == REG_CONTROL;
	wire       wr_config   = reg_write && reg_addr == REG_CONFIG;
	wire       wr_trackmap = reg_write && reg_addr == REG_TRACKMAP;
	wire [3:0] wr_delay    = reg_wdata[CFG_DELAY_LSB +: 4];
	wire       delay_legal = wr_delay <= DELAY_MAX || wr_delay == DELAY_AUTO;
	wire       map_legal   = reg_wdata[2:0] < MAP_PRESETS;

	wire [1:0] source_sel = ctrl[CTL_SOURCE_LSB +: 2];
	wire       indiv_rec  = ctrl[CTL_INDIV_BIT];
	wire       tally_set  = ctrl[CTL_STILL_BIT];
	wire       fast_set   = ctrl[CTL_FAST_BIT];
	wire       arm_enable = ctrl[CTL_ARM_EN_BIT];
	wire       timecode_track_record_enable  = ctrl[CTL_TC_REC_BIT];
	wire       video_mode = ctrl[CTL_VIDEO_BIT];

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl               <= CONTROL_RESET;
			emulation          <= EMUL_RESET;
			record_start_delay <= DELAY_AUTO;
			map_preset         <= MAP_RESET;
		end else begin
			if (wr_control)
				ctrl <= reg_wdata[7:0];
			if (wr_config)
				emulation <= reg_wdata[CFG_EMUL_LSB +: 3];
			if (wr_config && delay_legal)
				record_start_delay <= wr_delay;
			if (wr_trackmap && map_legal)
				map_preset <= reg_wdata[2:0];
		end
	end

	////////////////////////////////////////////////////////////////
	// command arbitration

	motion_t    motion;
	motion_t    next_motion;
	logic       record_own;
	logic       delay_fire;
	logic       delay_pending;

	// local wins a same-cycle tie
	wire        remote_take = cmd_valid && source_sel != SRC_OFF && cmd_source == source_sel
		&& !local_valid;
	wire        act_valid   = local_valid || remote_take;
	wire [3:0]  act_code    = local_valid ? local_code : cmd_code;
	wire        act_stop    = act_valid && act_code == CMD_STOP;
	wire        act_play    = act_valid && act_code == CMD_PLAY;
	wire        act_record  = act_valid && act_code == CMD_RECORD;
	wire        act_locate  = act_valid && act_code == CMD_LOCATE;
	wire        act_wind    = act_valid && (act_code == CMD_FFWD || act_code == CMD_REW);
	wire        act_halt    = act_stop || act_locate || act_wind;
	wire        id_request  = remote_take && cmd_code == CMD_IDENTITY;
	wire [3:0]  eff_delay   = record_start_delay == DELAY_AUTO ? AUTO_DELAY[emulation]
		: record_start_delay;
	wire        nine_pin    = source_sel == SRC_NINE_PIN;

	////////////////////////////////////////////////////////////////
	// frame timing and record delay

	logic [31:0] frame_count;
	wire         frame_wrap = frame_count == 32'(FRAME_CYCLES - 1);
	wire         use_video  = video_mode && video_sync_valid;
	wire         frame_tick = use_video ? video_frame_edge : frame_wrap;

	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			frame_count <= 32'h0;
		else
			frame_count <= frame_wrap ? 32'h0 : frame_count + 32'h1;
	end

	frame_delay_counter delay_timer (
		.clock   (clock),
		.rst     (rst),
		.start   (act_record),
		.cancel  (act_halt),
		.tick    (frame_tick),
		.delay   (eff_delay),
		.fire    (delay_fire),
		.pending (delay_pending)
	);

	// override only when linked by timecode, referenced to it and individual record (CTL_INDIV_BIT) is set
	wire follow_master = chase_active && !(tc_linked && tc_reference && indiv_rec);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			record_own    <= 1'b0;
			monitor_input <= 1'b0;
			record_active <= 1'b0;
		end else begin
			if (act_halt) begin
				record_own    <= 1'b0;
				monitor_input <= 1'b0;
			end else if (delay_fire) begin
				record_own    <= 1'b1;
				monitor_input <= 1'b1;
			end
			record_active <= follow_master ? master_record : record_own;
		end
	end

	////////////////////////////////////////////////////////////////
	// transport state

	always_comb begin
		next_motion = motion;
		if (act_stop)
			next_motion = mo_stop;
		else if (act_play || delay_fire)
			next_motion = mo_play;
		else if (act_locate)
			next_motion = mo_locate;
		else if (act_wind)
			next_motion = mo_wind;
		else begin
			case (motion)
				mo_locate: begin
					if (locate_reached)
						next_motion = nine_pin ? mo_pause : mo_stop;
				end
				default: next_motion = motion;
			endcase
		end
	end

	logic [31:0] show_count;
	logic [31:0] flash_count;
	logic        flash_phase;
	wire         flash_wrap = flash_count == 32'(FLASH_CYCLES - 1);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			motion         <= mo_stop;
			wind_reverse   <= 1'b0;
			locate_request <= 1'b0;
			locate_target  <= 24'h0;
		end else begin
			motion         <= next_motion;
			locate_request <= act_locate;
			if (act_wind)
				wind_reverse <= act_code == CMD_REW;
			if (act_locate)
				locate_target <= cmd_position;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			show_count  <= 32'h0;
			flash_count <= 32'h0;
			flash_phase <= 1'b0;
		end else begin
			if (act_locate)
				show_count <= 32'(SHOW_CYCLES);
			else if (show_count != 32'h0)
				show_count <= show_count - 32'h1;
			if (motion != mo_wind) begin
				flash_count <= 32'h0;
				flash_phase <= 1'b0;
			end else begin
				flash_count <= flash_wrap ? 32'h0 : flash_count + 32'h1;
				if (flash_wrap)
					flash_phase <= !flash_phase;
			end
		end
	end

	assign transport_play  = motion == mo_play;
	assign transport_pause = motion == mo_pause;
	assign transport_wind  = motion == mo_wind;
	assign wind_fast       = fast_set;
	assign target_display  = show_count != 32'h0;
	assign ffwd_lamp       = motion == mo_locate || (transport_wind && !wind_reverse);
	assign rew_lamp        = motion == mo_locate || (transport_wind && wind_reverse);
	assign shuttle_lamp    = transport_wind && flash_phase;
	assign tally_stop      = transport_pause && !tally_set;
	assign tally_still     = transport_pause && tally_set;

	////////////////////////////////////////////////////////////////
	// identity reply

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			identity_valid <= 1'b0;
			identity_code  <= 16'h0000;
		end else begin
			identity_valid <= id_request;
			if (id_request)
				identity_code <= IDENTITY_REPLY[emulation];
		end
	end

	////////////////////////////////////////////////////////////////
	// track arming

	function automatic logic map_hit(input logic [2:0] preset, input logic [2:0] trk,
		input logic digital, input logic [2:0] idx);
		logic       kind;
		logic [2:0] num;
		kind = 1'b1;
		num  = trk;
		case (preset)
			3'h0: begin kind = trk[2]; num = {1'b0, trk[1:0]}; end
			3'h1: begin kind = 1'b1; num = trk; end
			3'h2: begin kind = 1'b0; num = {1'b0, trk[1:0]}; end
			3'h3: begin kind = 1'b0; num = {1'b0, trk[2:1]}; end
			3'h4: begin kind = 1'b1; num = {1'b0, trk[1:0]}; end
			default: begin kind = 1'b1; num = {1'b0, trk[2:1]}; end
		endcase
		map_hit = kind == digital && num == idx && (digital || idx < 3'h4);
	endfunction

	wire arm_code   = act_code == CMD_ARM || act_code == CMD_DISARM;
	wire arm_value  = act_code == CMD_ARM;
	wire local_arm  = local_valid && arm_code;
	wire remote_arm = remote_take && arm_code && arm_enable;
	wire tc_route   = !cmd_track_digital && cmd_track_index == ANALOG3_INDEX && timecode_track_record_enable;

	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			tc_track_arm <= 1'b0;
		else if (remote_arm && tc_route)
			tc_track_arm <= arm_value;
	end

	genvar t;
	generate
		for (t = 0; t < 8; t++) begin : g_track
			wire hit = local_arm ? local_track == 3'(t) : remote_arm && !tc_route
				&& map_hit(map_preset, 3'(t), cmd_track_digital, cmd_track_index);
			always_ff @(posedge clock or posedge rst) begin
				if (rst)
					track_arm[t] <= 1'b0;
				else if (hit)
					track_arm[t] <= arm_value;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// register read

	wire [31:0] status_word = {7'h00, tc_track_arm, track_arm, 4'h0, eff_delay, 1'b0, use_video,
		transport_wind, transport_pause, motion == mo_locate, delay_pending, monitor_input, record_active};
	wire [31:0] read_word =
		reg_addr == REG_CONTROL  ? {24'h0, ctrl} :
		reg_addr == REG_CONFIG   ? {24'h0, record_start_delay, 1'b0, emulation} :
		reg_addr == REG_TRACKMAP ? {29'h0, map_preset} :
		reg_addr == REG_STATUS   ? status_word :
		reg_addr == REG_IDENTITY ? {16'h0, IDENTITY_REPLY[emulation]} : 32'h0;

	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			reg_rdata <= 32'h0;
		else
			reg_rdata <= reg_read ? read_word : 32'h0;
	end

	////////////////////////////////////////////////////////////////
	// checks

	a_source_gate: assert property (@(posedge clock) disable iff (rst)
		cmd_valid && (source_sel == SRC_OFF || cmd_source != source_sel) |-> !remote_take)
		else $error("command from unselected source taken");
	a_local_live: assert property (@(posedge clock) disable iff (rst)
		local_valid && local_code == CMD_STOP && source_sel != SRC_OFF |=> motion == mo_stop)
		else $error("local stop ignored");
	a_chase_follow: assert property (@(posedge clock) disable iff (rst)
		chase_active && !(tc_linked && tc_reference) |=> record_active == $past(master_record))
		else $error("slave not following master record");
	a_identity_reply: assert property (@(posedge clock) disable iff (rst)
		id_request |=> identity_valid && identity_code == IDENTITY_REPLY[$past(emulation)])
		else $error("wrong identity reply");
	a_zero_delay: assert property (@(posedge clock) disable iff (rst)
		act_record && eff_delay == 4'h0 |=> record_own && monitor_input)
		else $error("zero delay record not immediate");
	a_one_delay: assert property (@(posedge clock) disable iff (rst)
		act_record && eff_delay == 4'h1 ##1 (!act_valid && !frame_tick) [*2] ##1 !act_valid && frame_tick
		|=> record_own)
		else $error("delay one not at first frame");
	a_locate_pause: assert property (@(posedge clock) disable iff (rst)
		motion == mo_locate && locate_reached && nine_pin && !act_valid |=> transport_pause)
		else $error("locate did not pause");
	a_tally_report: assert property (@(posedge clock) disable iff (rst)
		transport_pause |-> tally_still == tally_set && tally_stop == !tally_set)
		else $error("wrong cue tally");
	a_wind_lamps: assert property (@(posedge clock) disable iff (rst)
		motion == mo_locate |-> ffwd_lamp && rew_lamp && !shuttle_lamp)
		else $error("locate lamps wrong");
	a_arm_block: assert property (@(posedge clock) disable iff (rst)
		remote_take && arm_code && !arm_enable |=> $stable(track_arm) && $stable(tc_track_arm))
		else $error("remote arm not blocked");
	a_tc_route: assert property (@(posedge clock) disable iff (rst)
		remote_arm && tc_route |=> tc_track_arm == $past(arm_value) && $stable(track_arm))
		else $error("analog 3 not routed to timecode track");

endmodule
`default_nettype wire

// [design/remote_ctrl_pkg.sv]
`default_nettype none
package remote_ctrl_pkg;

	localparam int unsigned CLOCK_HZ             = 125_000_000;
	localparam int unsigned INTERNAL_FRAME_MS    = 30;
	localparam int unsigned LOCATE_SHOW_S        = 3;
	localparam int unsigned SHUTTLE_FLASH_MS     = 250;
	localparam int unsigned INTERNAL_FRAME_CYCLES = CLOCK_HZ / 1000 * INTERNAL_FRAME_MS;
	localparam int unsigned LOCATE_SHOW_CYCLES   = CLOCK_HZ * LOCATE_SHOW_S;
	localparam int unsigned SHUTTLE_FLASH_CYCLES = CLOCK_HZ / 1000 * SHUTTLE_FLASH_MS;

	localparam logic [7:0] REG_CONTROL  = 8'h00;
	localparam logic [7:0] REG_CONFIG   = 8'h04;
	localparam logic [7:0] REG_TRACKMAP = 8'h08;
	localparam logic [7:0] REG_STATUS   = 8'h0C;
	localparam logic [7:0] REG_IDENTITY = 8'h10;

	localparam int CTL_SOURCE_LSB  = 0;
	localparam int CTL_INDIV_BIT   = 2;
	localparam int CTL_STILL_BIT   = 3;
	localparam int CTL_FAST_BIT    = 4;
	localparam int CTL_ARM_EN_BIT  = 5;
	localparam int CTL_TC_REC_BIT  = 6;
	localparam int CTL_VIDEO_BIT   = 7;
	localparam int CFG_EMUL_LSB    = 0;
	localparam int CFG_DELAY_LSB   = 4;
	localparam logic [7:0] CONTROL_RESET = 8'hA3;
	localparam logic [2:0] EMUL_RESET    = 3'h0;
	localparam logic [2:0] MAP_RESET     = 3'h0;

	localparam logic [1:0] SRC_NINE_PIN = 2'h0;
	localparam logic [1:0] SRC_MIDI     = 2'h1;
	localparam logic [1:0] SRC_BUS      = 2'h2;
	localparam logic [1:0] SRC_OFF      = 2'h3;

	localparam logic [3:0] CMD_STOP     = 4'h1;
	localparam logic [3:0] CMD_PLAY     = 4'h2;
	localparam logic [3:0] CMD_RECORD   = 4'h3;
	localparam logic [3:0] CMD_LOCATE   = 4'h4;
	localparam logic [3:0] CMD_FFWD     = 4'h5;
	localparam logic [3:0] CMD_REW      = 4'h6;
	localparam logic [3:0] CMD_ARM      = 4'h7;
	localparam logic [3:0] CMD_DISARM   = 4'h8;
	localparam logic [3:0] CMD_IDENTITY = 4'h9;

	localparam logic [3:0] DELAY_MAX    = 4'h9;
	localparam logic [3:0] DELAY_AUTO   = 4'hF;
	localparam logic [2:0] MAP_PRESETS  = 3'h6;
	localparam logic [2:0] ANALOG3_INDEX = 3'h2;

	// per emulation, index 0 first
	localparam logic [3:0] AUTO_DELAY [8] = '{4'h3, 4'h4, 4'h6, 4'h3, 4'h0, 4'h4, 4'h5, 4'h0};
	// arbitrary reply values
	localparam logic [15:0] IDENTITY_REPLY [8] = '{16'hA010, 16'hA011, 16'hA012, 16'hA013,
		16'hA014, 16'hA015, 16'hA016, 16'hA017};

	typedef enum logic [2:0] {mo_stop, mo_play, mo_locate, mo_pause, mo_wind} motion_t;

endpackage
`default_nettype wire

// [design/frame_delay_counter.sv]
`default_nettype none
module frame_delay_counter
	import remote_ctrl_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       start,
	input  wire logic       cancel,
	input  wire logic       tick,
	input  wire logic [3:0] delay,
	output logic            fire,
	output logic            pending
);

	logic [3:0] count;
	logic [3:0] target;
	logic       busy;

	wire [3:0] next_count = count + 4'h1;
	wire       at_target  = busy && tick && next_count == target;

	assign fire    = !cancel && (start ? delay == 4'h0 : at_target);
	assign pending = busy;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			busy   <= 1'b0;
			count  <= 4'h0;
			target <= 4'h0;
		end else if (cancel) begin
			busy  <= 1'b0;
			count <= 4'h0;
		end else if (start) begin
			count  <= 4'h0;
			target <= delay;
			busy   <= delay != 4'h0;
		end else if (busy && tick) begin
			count <= next_count;
			if (next_count == target)
				busy <= 1'b0;
		end
	end

	a_restart_clear: assert property (@(posedge clock) disable iff (rst)
		start && !cancel |=> count == 4'h0 && busy == ($past(delay) != 4'h0))
		else $error("delay count not restarted");
	a_fire_on_count: assert property (@(posedge clock) disable iff (rst)
		busy && tick && !start && !cancel && next_count == target |-> fire ##1 !busy)
		else $error("record start missed its frame");

endmodule
`default_nettype wire

// [sim/far_side_model.sv]
`default_nettype none
module far_side_model #(
	parameter int unsigned VIDEO_PERIOD = 7,
	parameter int unsigned LOCATE_TIME  = 5
)(
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic locate_request,
	output logic      video_frame_edge,
	output logic      locate_reached
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned vcount;
	int unsigned lcount;
	////////////////////////////////////////////////////////////////
	// free running frame boundary, one cycle wide
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			vcount <= 0;
			video_frame_edge <= 1'b0;
		end else begin
			vcount <= (vcount == VIDEO_PERIOD - 1) ? 0 : vcount + 1;
			video_frame_edge <= (vcount == VIDEO_PERIOD - 1);
		end
	end
	////////////////////////////////////////////////////////////////
	// seek ends some cycles after the request; pulse, not level
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lcount <= 0;
			locate_reached <= 1'b0;
		end else begin
			if (locate_request)
				lcount <= LOCATE_TIME;
			else if (lcount != 0)
				lcount <= lcount - 1;
			locate_reached <= (lcount == 1) && !locate_request;
		end
	end
endmodule
`default_nettype wire

// [sim/tb_remote_transport_control.sv]
`default_nettype none
module tb_remote_transport_control import remote_ctrl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock, rst, reg_write, reg_read, cmd_valid, cmd_track_digital, local_valid;
	logic        video_frame_edge, video_sync_valid, chase_active, tc_linked, tc_reference;
	logic        master_record, locate_reached, record_active, monitor_input, transport_play;
	logic        transport_pause, transport_wind, wind_reverse, wind_fast, locate_request;
	logic        target_display, ffwd_lamp, rew_lamp, shuttle_lamp, tally_stop, tally_still;
	logic        identity_valid, tc_track_arm, saw0, saw1;
	logic [1:0]  cmd_source;
	logic [2:0]  cmd_track_index, local_track;
	logic [3:0]  cmd_code, local_code;
	logic [7:0]  reg_addr, track_arm;
	logic [7:0]  exp_map [6] = '{8'h11, 8'h01, 8'h11, 8'h03, 8'h11, 8'h03};
	logic [15:0] identity_code;
	logic [23:0] cmd_position, locate_target;
	logic [31:0] reg_wdata, reg_rdata, v;
	int          n_fail, checks_done, cycles, n;

	remote_transport_control #(.FRAME_CYCLES(20), .SHOW_CYCLES(50), .FLASH_CYCLES(4)) dut (.clock, .rst,
		.reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .cmd_valid, .cmd_source, .cmd_code,
		.cmd_track_digital, .cmd_track_index, .cmd_position, .local_valid, .local_code, .local_track,
		.video_frame_edge, .video_sync_valid, .chase_active, .tc_linked, .tc_reference, .master_record,
		.locate_reached, .record_active, .monitor_input, .transport_play, .transport_pause,
		.transport_wind, .wind_reverse, .wind_fast, .locate_request, .locate_target, .target_display,
		.ffwd_lamp, .rew_lamp, .shuttle_lamp, .tally_stop, .tally_still, .identity_valid,
		.identity_code, .track_arm, .tc_track_arm);

	far_side_model partner (.clock, .rst, .locate_request, .video_frame_edge, .locate_reached);

	////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			give_verdict();
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("checks=%0d mismatches=%0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic wt(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		@(posedge clock);
		d = reg_rdata;
	endtask

	task automatic setc(input logic [7:0] c);
		wr(REG_CONTROL, 32'(c));
	endtask

	task automatic cmd(input logic loc, input logic [1:0] s, input logic [3:0] c, input logic dg,
		input logic [2:0] ix);
		@(posedge clock);
		if (loc) begin
			local_valid <= 1'b1;
			local_code <= c;
			local_track <= ix;
		end else begin
			cmd_valid <= 1'b1;
			cmd_source <= s;
			cmd_code <= c;
			cmd_track_digital <= dg;
			cmd_track_index <= ix;
		end
		@(posedge clock);
		cmd_valid <= 1'b0;
		local_valid <= 1'b0;
	endtask

	// frames counted only until the monitor switches
	task automatic rec_run(input logic [3:0] d, input bit vid);
		int e;
		e = 0;
		n = 0;
		wr(REG_CONFIG, 32'({d, 4'h0}));
		cmd(0, SRC_NINE_PIN, CMD_RECORD, 0, 0);
		while (record_active !== 1'b1 && n < 400) begin
			@(posedge clock);
			n++;
			if (video_frame_edge === 1'b1 && monitor_input !== 1'b1)
				e++;
		end
		chk(32'(monitor_input), 1);
		if (vid)
			chk(32'(e), 32'(d));
		else
			chk(32'(n > 20 * (d - 1) && n <= 20 * d + 3), 1);
		cmd(0, SRC_NINE_PIN, CMD_STOP, 0, 0);
		wt(1);
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		{rst, reg_write, reg_read, cmd_valid, cmd_track_digital, local_valid} = 6'h20;
		{chase_active, tc_linked, tc_reference, master_record} = 4'h0;
		{video_sync_valid, cmd_source, cmd_track_index, local_track, cmd_code, local_code} = 1'b1 << 16;
		{reg_addr, reg_wdata} = 40'h0;
		cmd_position = 24'h05A3C1;
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		rd(REG_CONTROL, v);
		chk(v, 32'hA3);
		rd(REG_CONFIG, v);
		chk(v, 32'hF0);
		rd(8'h14, v);
		chk(v, 0);
		cmd(0, SRC_NINE_PIN, CMD_PLAY, 0, 0);
		wt(1);
		chk(32'(transport_play), 0);
		for (int s = 0; s < 3; s++) begin
			setc({6'h28, 2'(s)});
			cmd(0, 2'((s + 1) % 3), CMD_PLAY, 0, 0);
			wt(1);
			chk(32'(transport_play), 0);
			cmd(0, 2'(s), CMD_PLAY, 0, 0);
			wt(1);
			chk(32'(transport_play), 1);
			cmd(1, 0, CMD_STOP, 0, 0);
			wt(1);
			chk(32'(transport_play), 0);
		end
		// back to nine-pin for the remote commands below
		setc(8'hA0);
		for (int e = 0; e < 8; e++) begin
			wr(REG_CONFIG, 32'({4'hF, 1'b0, 3'(e)}));
			cmd(0, SRC_NINE_PIN, CMD_IDENTITY, 0, 0);
			#1;
			chk(32'(identity_valid), 1);
			chk(32'(identity_code), 32'(IDENTITY_REPLY[e]));
			rd(REG_STATUS, v);
			chk(32'(v[11:8]), 32'(AUTO_DELAY[e]));
		end
		wr(REG_CONFIG, 32'hA0);
		rd(REG_CONFIG, v);
		chk(32'(v[7:4]), 32'hF);
		rec_run(0, 1);
		rec_run(1, 1);
		rec_run(9, 1);
		cmd(0, SRC_NINE_PIN, CMD_RECORD, 0, 0);
		wt(12);
		rec_run(9, 1);
		setc(8'h20);
		rec_run(2, 0);
		setc(8'hA0);
		video_sync_valid <= 1'b0;
		rec_run(2, 0);
		video_sync_valid <= 1'b1;
		chase_active <= 1'b1;
		master_record <= 1'b1;
		wt(3);
		chk(32'(record_active), 1);
		setc(8'hA4);
		tc_linked <= 1'b1;
		tc_reference <= 1'b1;
		wt(3);
		chk(32'(record_active), 0);
		setc(8'hA0);
		wt(2);
		chk(32'(record_active), 1);
		chase_active <= 1'b0;
		master_record <= 1'b0;
		cmd(0, SRC_NINE_PIN, CMD_LOCATE, 0, 0);
		// locate_request stands for this one cycle only
		#1;
		chk({locate_request, target_display, ffwd_lamp, rew_lamp, shuttle_lamp}, 5'h1E);
		chk(32'(locate_target), 32'h05A3C1);
		n = 0;
		while (transport_pause !== 1'b1 && n < 50) begin
			@(posedge clock);
			n++;
		end
		wt(1);
		chk({tally_stop, tally_still}, 2);
		setc(8'hA8);
		wt(1);
		chk({tally_stop, tally_still}, 1);
		wt(60);
		chk(32'(target_display), 0);
		setc(8'hB0);
		cmd(0, SRC_NINE_PIN, CMD_FFWD, 0, 0);
		wt(1);
		chk({wind_fast, transport_wind, ffwd_lamp, rew_lamp}, 4'hE);
		{saw0, saw1} = 2'b00;
		repeat (12) begin
			wt(1);
			saw0 |= (shuttle_lamp === 1'b0);
			saw1 |= (shuttle_lamp === 1'b1);
		end
		chk({saw0, saw1}, 3);
		setc(8'hA0);
		cmd(0, SRC_NINE_PIN, CMD_REW, 0, 0);
		wt(1);
		chk({wind_fast, wind_reverse, ffwd_lamp, rew_lamp}, 4'h5);
		cmd(0, SRC_NINE_PIN, CMD_STOP, 0, 0);
		for (int p = 0; p < 6; p++) begin
			wr(REG_TRACKMAP, 32'(p));
			cmd(0, SRC_NINE_PIN, CMD_ARM, 1, 0);
			cmd(0, SRC_NINE_PIN, CMD_ARM, 0, 0);
			wt(1);
			chk(32'(track_arm), 32'(exp_map[p]));
			cmd(0, SRC_NINE_PIN, CMD_DISARM, 1, 0);
			cmd(0, SRC_NINE_PIN, CMD_DISARM, 0, 0);
			wt(1);
			chk(32'(track_arm), 0);
		end
		wr(REG_TRACKMAP, 32'h6);
		rd(REG_TRACKMAP, v);
		chk(v, 5);
		wr(REG_TRACKMAP, 0);
		setc(8'hE0);
		cmd(0, SRC_NINE_PIN, CMD_ARM, 0, ANALOG3_INDEX);
		wt(1);
		chk({tc_track_arm, track_arm}, 9'h100);
		setc(8'hA0);
		cmd(0, SRC_NINE_PIN, CMD_ARM, 0, ANALOG3_INDEX);
		wt(1);
		chk(32'(track_arm), 32'h04);
		setc(8'h80);
		cmd(0, SRC_NINE_PIN, CMD_ARM, 1, 1);
		cmd(1, 0, CMD_ARM, 0, 6);
		wt(1);
		chk(32'(track_arm), 32'h44);
		give_verdict();
	end
endmodule
`default_nettype wire
